// ### bkseal_pkg.sv
// package: constants and state type of the backup mode and seal logic
package bkseal_pkg;
   // reset timeout period in ms and its cycle count at 10 MHz
   localparam int unsigned TRP_MS = 200;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TRP_CYC = TRP_MS * (CLK_HZ / 1000);
   localparam int unsigned TRP_HALF_CYC = TRP_CYC / 2;
   // seal sample point: a few cycles after the weak pull-up is applied
   localparam int unsigned SEAL_SETTLE_CYC = 16;
   localparam int unsigned CNT_W = 32;
   localparam logic RST_SEAL = 1'b0;
   localparam logic RST_BACKUP = 1'b0;
   typedef enum logic [1:0] {
      BKSEAL_RUN = 2'b00,
      BKSEAL_TO_HI = 2'b01,
      BKSEAL_TO_LO = 2'b11,
      BKSEAL_BACKUP = 2'b10
   } bkseal_state_t;
endpackage

// ### bkseal_sync.sv
// file: two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module bkseal_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// ### bkseal_ctrl.sv
// file: backup mode state and freshness-seal decision of the supervisor
`timescale 1ns/1ns
module bkseal_ctrl #(
   parameter int unsigned TRP_CYC = bkseal_pkg::TRP_CYC,
   parameter int unsigned SETTLE_CYC = bkseal_pkg::SEAL_SETTLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // analog comparator levels and pin inputs, asynchronous
   input wire logic supply_ok_i,
   input wire logic supply_low_sw_i,
   input wire logic backup_above_i,
   input wire logic sense_above_i,
   input wire logic manual_reset_in_n_i,
   input wire logic watchdog_kick_in_i,
   input wire logic wdog_expired_i,
   input wire logic sag_ok_i,
   input wire logic backup_ok_i,
   input wire logic power_fail_flag_out_i,
   output logic power_fail_flag_out_o,
   output logic power_fail_flag_out_oe_o,
   output logic flag_pullup_o,
   output logic reset_n_o,
   output logic timeout_alarm_out_o,
   output logic supply_sag_warn_n_o,
   output logic backup_good_out_o,
   output logic backup_active_out_o,
   output logic out_from_backup_o,
   output logic out_from_main_o,
   output logic gate_in_hiz_o,
   output logic gate_out_pull_backup_o,
   output logic kick_enable_o,
   output logic seal_armed_o
);
   localparam int CW = bkseal_pkg::CNT_W;
   logic [7:0] raw;
   logic [7:0] syn;
   logic sup_ok, sup_sw, bk_above, sense_ok, mr_n, wd_exp, sag_ok, bk_ok;
   logic flag_pin;
   logic kick_s;
   bkseal_pkg::bkseal_state_t st_q;
   logic [bkseal_pkg::CNT_W-1:0] cnt_q;
   logic seal_q;
   logic sampled_q;
   logic mr_prev_q;
   logic go_backup;
   logic mr_fall;
   logic [bkseal_pkg::CNT_W-1:0] half_c;
   logic [bkseal_pkg::CNT_W-1:0] end_c;
   logic [bkseal_pkg::CNT_W-1:0] smp_c;

   assign raw = {supply_ok_i, supply_low_sw_i, backup_above_i, sense_above_i,
      manual_reset_in_n_i, wdog_expired_i, sag_ok_i, backup_ok_i};

   bkseal_sync #(.W(8)) u_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i(raw),
      .sync_o(syn)
   );

   bkseal_sync #(.W(1)) u_sync_pin (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i(power_fail_flag_out_i),
      .sync_o(flag_pin)
   );

   // kick is a pin as well, so it takes the same two flops
   bkseal_sync #(.W(1)) u_sync_kick (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i(watchdog_kick_in_i),
      .sync_o(kick_s)
   );

   assign {sup_ok, sup_sw, bk_above, sense_ok, mr_n, wd_exp, sag_ok,
      bk_ok} = syn;

   assign end_c = CW'(TRP_CYC - 1);
   assign half_c = CW'(TRP_CYC / 2);
   assign smp_c = CW'(SETTLE_CYC);

   ////////////////////////////////////////////////////////////////////
   // backup entry and timeout sequencing

   // backup only below switchover with battery higher, never above reset
   assign go_backup = !sup_ok && sup_sw && bk_above;
   // manual reset is not looked at in backup
   assign mr_fall = mr_prev_q && !mr_n &&
      (st_q != bkseal_pkg::BKSEAL_BACKUP);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         // synchroniser leaves reset low, so high here would fake an edge
         mr_prev_q <= 1'b0;
      end else begin
         mr_prev_q <= mr_n;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_q <= bkseal_pkg::BKSEAL_TO_HI;
         cnt_q <= '0;
      end else begin
         unique case (st_q)
            bkseal_pkg::BKSEAL_RUN: begin
               cnt_q <= '0;
               if (go_backup && !seal_q) begin
                  st_q <= bkseal_pkg::BKSEAL_BACKUP;
               end else if (!sup_ok || mr_fall) begin
                  // manual reset starts a full timeout too
                  st_q <= bkseal_pkg::BKSEAL_TO_HI;
               end
            end
            bkseal_pkg::BKSEAL_TO_HI: begin
               if (go_backup && !seal_q) begin
                  st_q <= bkseal_pkg::BKSEAL_BACKUP;
                  cnt_q <= '0;
               end else if (!sup_ok || !mr_n) begin
                  cnt_q <= '0;
               end else if (cnt_q == half_c) begin
                  st_q <= bkseal_pkg::BKSEAL_TO_LO;
                  cnt_q <= cnt_q + 1'b1;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            bkseal_pkg::BKSEAL_TO_LO: begin
               if (!sup_ok || !mr_n) begin
                  st_q <= bkseal_pkg::BKSEAL_TO_HI;
                  cnt_q <= '0;
               end else if (cnt_q == end_c) begin
                  st_q <= bkseal_pkg::BKSEAL_RUN;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            bkseal_pkg::BKSEAL_BACKUP: begin
               cnt_q <= '0;
               if (sup_ok) begin
                  st_q <= bkseal_pkg::BKSEAL_TO_HI;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // seal decision

   // sample once per timeout, while detached and after the pull-up settles
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         seal_q <= bkseal_pkg::RST_SEAL;
         sampled_q <= 1'b0;
      end else if (st_q == bkseal_pkg::BKSEAL_RUN) begin
         sampled_q <= 1'b0;
      end else if (st_q == bkseal_pkg::BKSEAL_TO_HI && !sampled_q &&
                   cnt_q == smp_c) begin
         sampled_q <= 1'b1;
         seal_q <= !flag_pin;
      end else if (st_q == bkseal_pkg::BKSEAL_BACKUP) begin
         seal_q <= seal_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin and supply outputs

   logic in_bk;
   logic in_hi;
   assign in_bk = (st_q == bkseal_pkg::BKSEAL_BACKUP);
   assign in_hi = (st_q == bkseal_pkg::BKSEAL_TO_HI);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         power_fail_flag_out_o <= 1'b0;
         power_fail_flag_out_oe_o <= 1'b0;
         flag_pullup_o <= 1'b1;
      end else if (in_bk) begin
         power_fail_flag_out_o <= 1'b0;
         power_fail_flag_out_oe_o <= 1'b1;
         flag_pullup_o <= 1'b0;
      end else if (st_q == bkseal_pkg::BKSEAL_TO_HI ||
                   (go_backup && !seal_q) ||
                   (st_q == bkseal_pkg::BKSEAL_RUN &&
                    (!sup_ok || mr_fall))) begin
         // released and weakly held high: pin reads high unless grounded
         power_fail_flag_out_o <= 1'b1;
         power_fail_flag_out_oe_o <= 1'b0;
         flag_pullup_o <= 1'b1;
      end else begin
         // reattached in second half, well before the end
         power_fail_flag_out_o <= sense_ok;
         power_fail_flag_out_oe_o <= 1'b1;
         flag_pullup_o <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         out_from_backup_o <= bkseal_pkg::RST_BACKUP;
         out_from_main_o <= 1'b0;
         backup_active_out_o <= bkseal_pkg::RST_BACKUP;
      end else begin
         out_from_backup_o <= in_bk;
         out_from_main_o <= !in_bk && sup_ok;
         backup_active_out_o <= in_bk;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reset_n_o <= 1'b0;
         timeout_alarm_out_o <= 1'b0;
         supply_sag_warn_n_o <= 1'b0;
         backup_good_out_o <= 1'b0;
         gate_in_hiz_o <= 1'b1;
         gate_out_pull_backup_o <= 1'b0;
         kick_enable_o <= 1'b0;
      end else begin
         reset_n_o <= !in_bk && (st_q == bkseal_pkg::BKSEAL_RUN);
         timeout_alarm_out_o <= !in_bk && !wd_exp;
         supply_sag_warn_n_o <= !in_bk && sag_ok;
         backup_good_out_o <= !in_bk && bk_ok;
         gate_in_hiz_o <= in_bk || in_hi ||
            st_q == bkseal_pkg::BKSEAL_TO_LO;
         gate_out_pull_backup_o <= in_bk;
         kick_enable_o <= !in_bk && kick_s;
      end
   end

   assign seal_armed_o = seal_q;

   ////////////////////////////////////////////////////////////////////
   // checks

   logic [bkseal_pkg::CNT_W-1:0] run_len_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || st_q != bkseal_pkg::BKSEAL_TO_LO) begin
         run_len_q <= '0;
      end else begin
         run_len_q <= run_len_q + 1'b1;
      end
   end

   property p_flag_hi;
      @(posedge ref_clk_i) disable iff (srst_i)
         (st_q == bkseal_pkg::BKSEAL_TO_HI) |=> power_fail_flag_out_o;
   endproperty
   first_half_high_a: assert property (p_flag_hi)
      else $error("flag not high in first half");

   detach_first_half_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) in_hi |=> !power_fail_flag_out_oe_o)
      else $error("flag not detached in first half");

   reattach_before_end_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) (st_q == bkseal_pkg::BKSEAL_TO_LO) ##1
      (st_q == bkseal_pkg::BKSEAL_TO_LO) |-> power_fail_flag_out_oe_o)
      else $error("flag not reattached before timeout end");

   seal_low_only_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) $rose(seal_q) |-> $past(!flag_pin))
      else $error("seal armed without low sample");

   seal_blocks_backup_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) seal_q && !in_bk |=> !in_bk)
      else $error("backup entered while sealed");

   no_backup_supply_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) sup_ok && !in_bk |=> !in_bk)
      else $error("backup entered with supply good");

   backup_outputs_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) in_bk ##1 in_bk |-> !reset_n_o &&
      !backup_good_out_o && !supply_sag_warn_n_o && !timeout_alarm_out_o &&
      !power_fail_flag_out_o)
      else $error("status outputs not low in backup");

   backup_active_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) backup_active_out_o == out_from_backup_o)
      else $error("backup active disagrees with switch");

   supply_cut_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) out_from_backup_o |-> !out_from_main_o)
      else $error("both sources on output");

   mr_ignored_a: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) in_bk && !sup_ok && !mr_n |=> in_bk)
      else $error("manual reset acted in backup");

   cover_seal: cover property (@(posedge ref_clk_i) $rose(seal_q));
   cover_backup: cover property (@(posedge ref_clk_i) $rose(in_bk));
   cover_second: cover property (@(posedge ref_clk_i) run_len_q == 32'h1);
endmodule

// ### bkseal_host.sv
// host side model: resolves the power-fail flag pin, may ground it
`timescale 1ns/1ns
module bkseal_host (
   input wire logic ref_clk_i,
   input wire logic flag_drv_i,
   input wire logic flag_oe_i,
   input wire logic pullup_i,
   input wire logic ground_i,
   output logic pin_o
);
   logic spin_q = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // a floating pin wanders, so a stale level never passes for a result
   always @(posedge ref_clk_i) begin
      spin_q <= ~spin_q;
   end
   always_comb begin
      if (flag_oe_i) begin
         pin_o = flag_drv_i;
      end else if (ground_i) begin
         pin_o = 1'b0;
      end else if (pullup_i) begin
         pin_o = 1'b1;
      end else begin
         pin_o = spin_q;
      end
   end
endmodule

// ### backup_mode_and_seal_logic_tb.sv
// testbench of the backup mode and seal logic
`timescale 1ns/1ns
module backup_mode_and_seal_logic_tb;
   localparam int unsigned TRP = 64;
   localparam int unsigned SET = 4;
   // backup mode levels, bit per output index below (oe not checked)
   localparam logic [13:0] BK_EXP = 14'h0c0c;
   typedef struct {int id; logic v;} bkseal_note_t;
   string names[14] = '{"seal", "reset_n", "backup_active", "from_backup",
      "flag_oe", "flag_pin", "from_main", "alarm", "sag_warn_n",
      "backup_good", "gate_in_hiz", "gate_out_pull", "kick_en", "pullup"};
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply_ok = 1'b1;
   logic low_sw = 1'b0;
   logic bk_above = 1'b0;
   logic sense = 1'b1;
   logic mr_n = 1'b1;
   logic kick = 1'b0;
   logic wd_exp = 1'b0;
   logic sag_ok = 1'b1;
   logic bk_ok = 1'b1;
   logic gnd = 1'b1;
   logic pin, drv, oe, pu, rst_n, alarm, sag_n, bgood, bon;
   logic from_bk, from_main, gin, gout, kick_en, seal;
   logic [13:0] outs;
   int miscompares = 0;
   int checked = 0;
   int seed = 69167;
   bkseal_note_t notes[$];
   event look;
   assign outs = {pu, kick_en, gout, gin, bgood, sag_n, alarm, from_main, pin,
      oe, from_bk, bon, rst_n, seal};
   always #50 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////////////////////////////////////
   bkseal_ctrl #(.TRP_CYC(TRP), .SETTLE_CYC(SET)) u_bkseal_ctrl (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .supply_ok_i(supply_ok),
      .supply_low_sw_i(low_sw), .backup_above_i(bk_above),
      .sense_above_i(sense), .manual_reset_in_n_i(mr_n),
      .watchdog_kick_in_i(kick), .wdog_expired_i(wd_exp),
      .sag_ok_i(sag_ok), .backup_ok_i(bk_ok), .power_fail_flag_out_i(pin),
      .power_fail_flag_out_o(drv), .power_fail_flag_out_oe_o(oe),
      .flag_pullup_o(pu), .reset_n_o(rst_n), .timeout_alarm_out_o(alarm),
      .supply_sag_warn_n_o(sag_n), .backup_good_out_o(bgood),
      .backup_active_out_o(bon), .out_from_backup_o(from_bk),
      .out_from_main_o(from_main), .gate_in_hiz_o(gin),
      .gate_out_pull_backup_o(gout), .kick_enable_o(kick_en),
      .seal_armed_o(seal));
   bkseal_host u_bkseal_host (.ref_clk_i(ref_clk_i), .flag_drv_i(drv),
      .flag_oe_i(oe), .pullup_i(pu), .ground_i(gnd), .pin_o(pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   // note the expectation, then let the watcher compare it
   task automatic check_lvl(input int id, input logic v);
      bkseal_note_t t;
      t.id = id;
      t.v = v;
      notes.push_back(t);
      -> look;
      #1;
   endtask
   task automatic do_reset(input logic g);
      gnd = g;
      srst_i = 1'b1;
      cyc(3);
      srst_i = 1'b0;
   endtask
   // host lets go of the pin before the device drives it again
   task automatic timeout_walk(input logic g, input logic s);
      cyc(12);
      check_lvl(4, 1'b0);
      check_lvl(5, ~g);
      check_lvl(13, 1'b1);
      cyc(8);
      gnd = 1'b0;
      cyc(32);
      check_lvl(4, 1'b1);
      check_lvl(5, sense);
      check_lvl(1, 1'b0);
      check_lvl(13, 1'b0);
      cyc(40);
      check_lvl(1, 1'b1);
      check_lvl(0, s);
      check_lvl(6, 1'b1);
   endtask
   task automatic manual_walk(input logic g, input logic s);
      mr_n = 1'b0;
      cyc(5);
      mr_n = 1'b1;
      gnd = g;
      timeout_walk(g, s);
   endtask
   task automatic backup_check();
      for (int i = 0; i < 14; i++) begin
         if (i != 4) check_lvl(i, BK_EXP[i]);
      end
   endtask
   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      bkseal_note_t n;
      forever begin
         @(look);
         n = notes.pop_front();
         checked++;
         if (outs[n.id] !== n.v) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", names[n.id], n.v,
               outs[n.id]);
         end
      end
   end
   initial begin
      #(3000 * 100);
      miscompares++;
      close_out();
   end
   initial begin
      cyc(20);
      srst_i = 1'b0;
      timeout_walk(1'b1, 1'b1);
      {supply_ok, low_sw, bk_above} = 3'h3;
      cyc(10);
      check_lvl(3, 1'b0);
      check_lvl(2, 1'b0);
      {supply_ok, low_sw, bk_above} = 3'h4;
      do_reset(1'b0);
      timeout_walk(1'b0, 1'b0);
      bk_above = 1'b1;
      cyc(6);
      check_lvl(2, 1'b0);
      check_lvl(3, 1'b0);
      bk_above = 1'b0;
      sense = 1'b0;
      manual_walk(1'b0, 1'b0);
      manual_walk(1'b1, 1'b1);
      sense = 1'b1;
      do_reset(1'b0);
      timeout_walk(1'b0, 1'b0);
      {supply_ok, low_sw, bk_above} = 3'h3;
      cyc(10);
      backup_check();
      // inputs that backup mode must ignore get random levels
      repeat (8) begin
         {kick, wd_exp, sag_ok, bk_ok, sense, mr_n} = 6'($random(seed));
         cyc(4);
         backup_check();
      end
      {kick, wd_exp, sag_ok, bk_ok, sense, mr_n} = 6'h33;
      {supply_ok, low_sw, bk_above} = 3'h4;
      timeout_walk(1'b0, 1'b0);
      // status outputs and kick come back once backup is left
      {wd_exp, sag_ok, bk_ok} = 3'h3;
      cyc(4);
      check_lvl(7, 1'b1);
      check_lvl(8, 1'b1);
      check_lvl(9, 1'b1);
      check_lvl(12, 1'b1);
      cyc(2);
      close_out();
   end
endmodule
